/* File: rtl/stp_pkg.sv */
// shared constants for the serial to network packer
package stp_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DELIM = 8'h04;
  localparam logic [7:0] OFS_PKTLEN = 8'h08;
  localparam logic [7:0] OFS_FORCE = 8'h0c;
  localparam logic [7:0] OFS_INACT = 8'h10;
  localparam logic [7:0] OFS_ALIVE = 8'h14;
  localparam logic [7:0] OFS_MAXCONN = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_INT_STAT = 8'h20;
  localparam logic [7:0] OFS_INT_CLR = 8'h24;
  localparam logic [7:0] OFS_INT_EN = 8'h28;
  // control field positions
  localparam int CTRL_D1_EN = 0;
  localparam int CTRL_D2_EN = 1;
  localparam int CTRL_PROC_LO = 2;
  localparam int CTRL_SKIP = 4;
  localparam int CTRL_RTS_LOW = 5;
  localparam int CTRL_DTR_LOW = 6;
  localparam int CTRL_RTS_VAL = 7;
  localparam int CTRL_DTR_VAL = 8;
  localparam int CTRL_W = 9;
  // reset values
  localparam logic [8:0] CTRL_RST = 9'h180;
  localparam logic [6:0] ALIVE_RST = 7'h07;
  localparam logic [3:0] MAXCONN_RST = 4'h1;
  localparam logic [3:0] MAXCONN_MAX = 4'h8;
  // interrupt event bits
  localparam int EV_PKT = 0;
  localparam int EV_INACT = 1;
  localparam int EV_ALIVE = 2;
  localparam int EV_W = 3;
  // timing
  localparam int CLK_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_NS;
  localparam int MS_PER_MIN = 60000;
  localparam int BUF_DEPTH = 1024;
  // delimiter post-processing
  typedef enum logic [1:0] {
    PROC_NONE = 2'b00,
    PROC_PLUS1 = 2'b01,
    PROC_PLUS2 = 2'b10,
    PROC_STRIP = 2'b11
  } stp_proc_e;
  typedef enum logic [0:0] {
    ST_FILL = 1'b0,
    ST_SEND = 1'b1
  } stp_state_e;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* File: rtl/stp_packer.sv */
// serial byte packer with connection supervision and axi4-lite registers
// Function
// - release when count reaches nonzero packet length
// - zero length: release only on delimiter/full/idle gap
// - one delimiter byte, or two in sequence
// - delimiters: accumulate until full or sequence
// - delimiter process ignored when first disabled
// - do-nothing releases including delimiters immediately
// - plus-one waits one further byte
// - plus-two waits two further bytes
// - strip removes delimiter bytes from packet
// - idle gap expiry releases buffer
// - close connection after inactivity limit
// - keep-alive probes, close on no answer
// - unresponsive host suspends all unless skipped
// - refuse connections beyond configured maximum
// - drive-low option lowers handshake on drop
// - hold-high option keeps handshake high
`timescale 1ns/1ps
module stp_packer #(
  parameter int DEPTH = stp_pkg::BUF_DEPTH,
  parameter int CYC_MS = stp_pkg::CYC_PER_MS,
  parameter int MS_MIN = stp_pkg::MS_PER_MIN
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic tx_last,
  input wire logic tx_ready,
  input wire logic link_up,
  input wire logic net_activity,
  input wire logic [7:0] conn_active,
  input wire logic [7:0] host_unresp,
  input wire logic ka_resp,
  output logic ka_probe,
  output logic conn_close,
  output logic conn_accept_ok,
  output logic [7:0] host_tx_en,
  output logic rts_out,
  output logic dtr_out,
  output logic irq
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int AW = $clog2(DEPTH);
  localparam int PW = $clog2(CYC_MS);
  localparam int MW = $clog2(MS_MIN);

  logic [stp_pkg::CTRL_W-1:0] ctrl_reg;
  logic [15:0] delim_reg;
  logic [10:0] pktlen_reg;
  logic [15:0] force_reg, inact_reg;
  logic [6:0] alive_reg;
  logic [3:0] maxconn_reg;
  logic [stp_pkg::EV_W-1:0] int_stat_reg, int_en_reg, ev;
  logic [7:0] awaddr_reg;
  logic aw_got_reg, w_got_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_do;
  logic [31:0] rd_mux;
  logic rd_hit;

  logic [7:0] mem [DEPTH];
  stp_pkg::stp_state_e state_reg, state_next;
  logic [CW-1:0] cnt_reg, send_len_reg, send_len_next, rd_idx_reg;
  logic [1:0] tail_reg;
  logic [7:0] prev_reg;
  logic acc, d1_en, d2_en, match, len_hit, full_hit, tail_done, rel_byte;
  logic [CW-1:0] cnt1;
  logic [1:0] dlen;
  stp_pkg::stp_proc_e proc;
  logic [PW-1:0] idle_pre_reg, tick_pre_reg;
  logic [15:0] idle_ms_reg, inact_ms_reg;
  logic idle_fire, ms_tick;
  logic [MW-1:0] min_pre_reg;
  logic [6:0] alive_min_reg;
  logic suspend;
  logic [3:0] nconn;

  // write channel: address and data taken in either order
  assign wr_do = aw_got_reg && w_got_reg && !s_axi_bvalid;
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= stp_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_do)
      begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_reg <= stp_pkg::OFS_INT_EN && awaddr_reg[1:0] == 2'b00 &&
          awaddr_reg != stp_pkg::OFS_STATUS && awaddr_reg != stp_pkg::OFS_INT_STAT) ?
          stp_pkg::RESP_OKAY : stp_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // configuration registers; only the byte lane 0 strobe is checked, and it gates the whole write
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ctrl_reg <= stp_pkg::CTRL_RST;
      delim_reg <= 16'h0;
      pktlen_reg <= 11'h0;
      force_reg <= 16'h0;
      inact_reg <= 16'h0;
      alive_reg <= stp_pkg::ALIVE_RST;
      maxconn_reg <= stp_pkg::MAXCONN_RST;
      int_en_reg <= '0;
    end
    else if (wr_do && wstrb_reg[0])
    begin
      case (awaddr_reg)
        stp_pkg::OFS_CTRL: ctrl_reg <= wdata_reg[stp_pkg::CTRL_W-1:0];
        stp_pkg::OFS_DELIM: delim_reg <= wdata_reg[15:0];
        stp_pkg::OFS_PKTLEN: pktlen_reg <= (wdata_reg[10:0] > 11'h400) ? 11'h400 : wdata_reg[10:0];
        stp_pkg::OFS_FORCE: force_reg <= wdata_reg[15:0];
        stp_pkg::OFS_INACT: inact_reg <= wdata_reg[15:0];
        stp_pkg::OFS_ALIVE: alive_reg <= (wdata_reg[6:0] > 7'h63) ? 7'h63 : wdata_reg[6:0];
        // out-of-range maximum is clamped into 1..8
        stp_pkg::OFS_MAXCONN: maxconn_reg <= (wdata_reg[3:0] == 4'h0) ? 4'h1 :
          (wdata_reg[3:0] > stp_pkg::MAXCONN_MAX) ? stp_pkg::MAXCONN_MAX : wdata_reg[3:0];
        stp_pkg::OFS_INT_EN: int_en_reg <= wdata_reg[stp_pkg::EV_W-1:0];
        default: ;
      endcase
    end
  end

  // sticky events; a new event beats a simultaneous clear
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      int_stat_reg <= '0;
    else if (wr_do && wstrb_reg[0] && awaddr_reg == stp_pkg::OFS_INT_CLR)
      int_stat_reg <= (int_stat_reg & ~wdata_reg[stp_pkg::EV_W-1:0]) | ev;
    else
      int_stat_reg <= int_stat_reg | ev;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      irq <= 1'b0;
    else
      irq <= |(int_stat_reg & int_en_reg);
  end

  // read mux; unmapped and write-only words answer slverr with zero
  always_comb
  begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      stp_pkg::OFS_CTRL: rd_mux = {23'h0, ctrl_reg};
      stp_pkg::OFS_DELIM: rd_mux = {16'h0, delim_reg};
      stp_pkg::OFS_PKTLEN: rd_mux = {21'h0, pktlen_reg};
      stp_pkg::OFS_FORCE: rd_mux = {16'h0, force_reg};
      stp_pkg::OFS_INACT: rd_mux = {16'h0, inact_reg};
      stp_pkg::OFS_ALIVE: rd_mux = {25'h0, alive_reg};
      stp_pkg::OFS_MAXCONN: rd_mux = {28'h0, maxconn_reg};
      stp_pkg::OFS_STATUS: rd_mux = {17'h0, link_up, suspend, state_reg == stp_pkg::ST_SEND,
        1'b0, 11'(cnt_reg)};
      stp_pkg::OFS_INT_STAT: rd_mux = {29'h0, int_stat_reg};
      stp_pkg::OFS_INT_EN: rd_mux = {29'h0, int_en_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= stp_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? stp_pkg::RESP_OKAY : stp_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // release decision for each accepted byte
  assign acc = rx_valid && rx_ready;
  assign d1_en = ctrl_reg[stp_pkg::CTRL_D1_EN];
  assign d2_en = ctrl_reg[stp_pkg::CTRL_D2_EN] && d1_en;
  assign proc = stp_pkg::stp_proc_e'(ctrl_reg[stp_pkg::CTRL_PROC_LO +: 2]);
  assign cnt1 = cnt_reg + CW'(1);
  assign dlen = d2_en ? 2'd2 : 2'd1;
  assign match = d1_en && tail_reg == 2'd0 && (d2_en ?
    (cnt_reg != '0 && prev_reg == delim_reg[7:0] && rx_data == delim_reg[15:8]) :
    rx_data == delim_reg[7:0]);
  // zero length leaves delimiter and full
  assign len_hit = pktlen_reg != 11'h0 && cnt1 == CW'(pktlen_reg);
  assign full_hit = cnt1 == CW'(DEPTH);
  assign tail_done = tail_reg == 2'd1;
  // delimiter process only matters when match can be true
  assign rel_byte = len_hit || full_hit || tail_done ||
    (match && (proc == stp_pkg::PROC_NONE || proc == stp_pkg::PROC_STRIP));
  assign idle_fire = idle_ms_reg == force_reg && force_reg != 16'h0 && cnt_reg != '0;

  always_comb
  begin
    state_next = state_reg;
    send_len_next = cnt_reg;
    case (state_reg)
      stp_pkg::ST_FILL:
      begin
        if (acc && rel_byte)
        begin
          state_next = stp_pkg::ST_SEND;
          send_len_next = (match && proc == stp_pkg::PROC_STRIP && !len_hit && !full_hit) ?
            cnt1 - CW'(dlen) : cnt1;
        end
        else if (!acc && idle_fire)
          state_next = stp_pkg::ST_SEND;
      end
      stp_pkg::ST_SEND:
        if (rd_idx_reg == send_len_reg && (!tx_valid || tx_ready))
          state_next = stp_pkg::ST_FILL;
      default: state_next = stp_pkg::ST_FILL;
    endcase
  end

  // buffer fill; input stalls while a packet drains
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_reg <= stp_pkg::ST_FILL;
      cnt_reg <= '0;
      send_len_reg <= '0;
      tail_reg <= 2'd0;
      prev_reg <= 8'h00;
      rx_ready <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      rx_ready <= state_next == stp_pkg::ST_FILL;
      if (state_reg == stp_pkg::ST_FILL && state_next == stp_pkg::ST_SEND)
      begin
        send_len_reg <= send_len_next;
        tail_reg <= 2'd0;
      end
      if (acc)
      begin
        mem[cnt_reg[AW-1:0]] <= rx_data;
        prev_reg <= rx_data;
        cnt_reg <= cnt1;
        // arm tail of one or two bytes
        if (match && proc == stp_pkg::PROC_PLUS1)
          tail_reg <= 2'd1;
        else if (match && proc == stp_pkg::PROC_PLUS2)
          tail_reg <= 2'd2;
        else if (tail_reg != 2'd0)
          tail_reg <= tail_reg - 2'd1;
      end
      if (state_reg == stp_pkg::ST_SEND && state_next == stp_pkg::ST_FILL)
        cnt_reg <= '0;
    end
  end

  // suspend whole stream or only the stuck hosts
  assign suspend = !ctrl_reg[stp_pkg::CTRL_SKIP] && |(host_unresp & conn_active);

  // packet drain
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      rd_idx_reg <= '0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
      host_tx_en <= 8'h00;
    end
    else
    begin
      host_tx_en <= conn_active & ~host_unresp;
      if (state_reg == stp_pkg::ST_SEND && (!tx_valid || tx_ready) && rd_idx_reg != send_len_reg && !suspend)
      begin
        tx_valid <= 1'b1;
        tx_data <= mem[rd_idx_reg[AW-1:0]];
        tx_last <= rd_idx_reg + CW'(1) == send_len_reg;
        rd_idx_reg <= rd_idx_reg + CW'(1);
      end
      else if (tx_valid && tx_ready)
        tx_valid <= 1'b0;
      if (state_reg == stp_pkg::ST_SEND && state_next == stp_pkg::ST_FILL)
        rd_idx_reg <= '0;
    end
  end

  // idle timer restarts per byte, held while empty
  always_ff @(posedge sys_clk)
  begin
    if (reset || acc || cnt_reg == '0 || state_reg != stp_pkg::ST_FILL)
    begin
      idle_pre_reg <= '0;
      idle_ms_reg <= 16'h0;
    end
    else if (idle_pre_reg == PW'(CYC_MS - 1))
    begin
      idle_pre_reg <= '0;
      // a zero limit never fires, counter saturates
      if (idle_ms_reg != 16'hffff)
        idle_ms_reg <= idle_ms_reg + 16'h1;
    end
    else
      idle_pre_reg <= idle_pre_reg + PW'(1);
  end

  // free-running millisecond and minute ticks for supervision
  assign ms_tick = tick_pre_reg == PW'(CYC_MS - 1);
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      tick_pre_reg <= '0;
      min_pre_reg <= '0;
    end
    else
    begin
      tick_pre_reg <= ms_tick ? '0 : tick_pre_reg + PW'(1);
      if (ms_tick)
        min_pre_reg <= (min_pre_reg == MW'(MS_MIN - 1)) ? '0 : min_pre_reg + MW'(1);
    end
  end

  // connection supervision; limits are coarse by up to one tick
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      inact_ms_reg <= 16'h0;
      alive_min_reg <= 7'h0;
      conn_close <= 1'b0;
      ka_probe <= 1'b0;
      ev <= '0;
    end
    else
    begin
      conn_close <= 1'b0;
      ka_probe <= 1'b0;
      ev <= '0;
      ev[stp_pkg::EV_PKT] <= state_reg == stp_pkg::ST_FILL && state_next == stp_pkg::ST_SEND;
      if (!link_up || acc || tx_valid || net_activity)
        inact_ms_reg <= 16'h0;
      else if (ms_tick && inact_ms_reg != 16'hffff)
        inact_ms_reg <= inact_ms_reg + 16'h1;
      // inactivity close
      // at or past the limit, so a lowered limit still closes
      if (link_up && inact_reg != 16'h0 && inact_ms_reg >= inact_reg)
      begin
        conn_close <= 1'b1;
        ev[stp_pkg::EV_INACT] <= 1'b1;
        inact_ms_reg <= 16'h0;
      end
      // probe each minute, close when unanswered
      if (!link_up || ka_resp)
        alive_min_reg <= 7'h0;
      else if (ms_tick && min_pre_reg == MW'(MS_MIN - 1))
      begin
        ka_probe <= alive_reg != 7'h0;
        alive_min_reg <= alive_min_reg + 7'h1;
      end
      if (link_up && alive_reg != 7'h0 && alive_min_reg >= alive_reg)
      begin
        conn_close <= 1'b1;
        ev[stp_pkg::EV_ALIVE] <= 1'b1;
        alive_min_reg <= 7'h0;
      end
    end
  end

  // admission flag from live connection count
  always_comb
  begin
    nconn = 4'h0;
    for (int i = 0; i < 8; i++)
      nconn = nconn + {3'h0, conn_active[i]};
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      conn_accept_ok <= 1'b0;
      rts_out <= 1'b0;
      dtr_out <= 1'b0;
    end
    else
    begin
      conn_accept_ok <= nconn < maxconn_reg;
      rts_out <= link_up ? ctrl_reg[stp_pkg::CTRL_RTS_VAL] : !ctrl_reg[stp_pkg::CTRL_RTS_LOW];
      dtr_out <= link_up ? ctrl_reg[stp_pkg::CTRL_DTR_VAL] : !ctrl_reg[stp_pkg::CTRL_DTR_LOW];
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  chk_len_release: assert property (state_reg == stp_pkg::ST_FILL && acc && len_hit |=> state_reg == stp_pkg::ST_SEND) else $error("length release missed");
  chk_zero_len: assert property (state_reg == stp_pkg::ST_FILL && acc && pktlen_reg == 11'h0 && !full_hit && !d1_en && !idle_fire |=> state_reg == stp_pkg::ST_FILL) else $error("zero length released");
  chk_full_release: assert property (state_reg == stp_pkg::ST_FILL && acc && full_hit |=> state_reg == stp_pkg::ST_SEND && send_len_reg == CW'(DEPTH)) else $error("full buffer held");
  chk_strip_len: assert property (state_reg == stp_pkg::ST_FILL && acc && match && proc == stp_pkg::PROC_STRIP && !len_hit && !full_hit |=> send_len_reg == $past(cnt_reg) + CW'(1) - CW'(dlen)) else $error("strip length wrong");
  chk_idle_zero: assert property (force_reg == 16'h0 && state_reg == stp_pkg::ST_FILL && !acc |=> state_reg == stp_pkg::ST_FILL) else $error("idle release with zero");
  chk_idle_release: assert property (state_reg == stp_pkg::ST_FILL && !acc && idle_fire |=> state_reg == stp_pkg::ST_SEND) else $error("idle release missed");
  chk_suspend_hold: assert property (state_reg == stp_pkg::ST_SEND && suspend && !tx_valid |=> !tx_valid) else $error("sent while suspended");
  chk_max_conn: assert property (nconn >= maxconn_reg |=> !conn_accept_ok) else $error("admission over maximum");
  chk_rts_low: assert property (!link_up && ctrl_reg[stp_pkg::CTRL_RTS_LOW] |=> !rts_out) else $error("rts not low on drop");
  chk_rts_high: assert property (!link_up && !ctrl_reg[stp_pkg::CTRL_RTS_LOW] |=> rts_out) else $error("rts not high on drop");
  chk_inact_close: assert property (link_up && inact_reg != 16'h0 && inact_ms_reg == inact_reg |=> conn_close) else $error("inactivity close missed");
endmodule // stp_packer

/* File: tb/stp_net_model.sv */
// network side sink model that stalls its ready and records packets
`timescale 1ns/1ps
module stp_net_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  output logic tx_ready,
  input wire logic slow
);
  logic [7:0] got[$];
  int n_pkt;
  logic [3:0] lfsr_reg;
  // slow mode drops ready on most cycles so held bytes get exercised
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      lfsr_reg <= 4'h1;
      tx_ready <= 1'b0;
      n_pkt <= 0;
    end
    else
    begin
      lfsr_reg <= {lfsr_reg[2:0], lfsr_reg[3] ^ lfsr_reg[2]};
      tx_ready <= slow ? (lfsr_reg[1:0] == 2'b11) : 1'b1;
      if (tx_valid === 1'b1 && tx_ready)
      begin
        got.push_back(tx_data);
        if (tx_last === 1'b1)
          n_pkt <= n_pkt + 1;
      end
    end
  end
endmodule // stp_net_model

/* File: tb/tb_stp_packer.sv */
// self-checking bench for the serial packer
`timescale 1ns/1ps
module tb_stp_packer;
  typedef logic [7:0] stp_bq_t[$];
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, rx_data = 8'h00, conn_active = 8'h01, host_unresp = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, rx_valid = 1'b0, link_up = 1'b1, slow = 1'b0, zero = 1'b0;
  logic bready = 1'b0, rready = 1'b0, ka_resp = 1'b0;
  logic [31:0] wdata = 32'h0, seed = 32'hde3a, rdata, d;
  logic awready, wready, bvalid, arready, rvalid, rx_ready, tx_valid, tx_last, tx_ready, ka_probe, conn_close;
  logic ok, rts, dtr, irq;
  logic [1:0] bresp, rresp, r;
  logic [7:0] tx_data, tx_en;
  int n_fail = 0, checks = 0, cyc = 0, n0, nd, a, b, n_close = 0, n_probe = 0;
  stp_bq_t s;

  // small counts keep the millisecond timers short
  stp_packer #(.DEPTH(16), .CYC_MS(10), .MS_MIN(4)) stp_packer_inst (.sys_clk(sys_clk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .link_up(link_up), .net_activity(zero),
    .conn_active(conn_active), .host_unresp(host_unresp), .ka_resp(ka_resp), .ka_probe(ka_probe),
    .conn_close(conn_close), .conn_accept_ok(ok), .host_tx_en(tx_en), .rts_out(rts), .dtr_out(dtr), .irq(irq));

  stp_net_model stp_net_model_inst (.sys_clk(sys_clk), .reset(reset), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_ready(tx_ready), .slow(slow));

  // bit4 set keeps random bytes clear of both delimiter codes
  function automatic logic [7:0] rnd8();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0] | 8'h10;
  endfunction

  // stripped delimiters always sit at the tail of the packet
  function automatic stp_bq_t expect_pkt(stp_bq_t q, int strip_n);
    stp_bq_t e;
    e = q;
    repeat (strip_n) void'(e.pop_back());
    return e;
  endfunction

  // waits for the answer; only the hang guard ends a stuck wait
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    awaddr <= ad;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    r = bresp;
    // idle edge keeps the next call off this step
    bready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] ad);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  // valid stays up between bytes, though each byte re-assigns it high with its data
  task automatic send(input stp_bq_t q);
    int k;
    foreach (q[i])
    begin
      rx_data <= q[i];
      rx_valid <= 1'b1;
      k = 0;
      do @(posedge sys_clk); while (rx_ready !== 1'b1 && k++ < 200);
    end
    rx_valid <= 1'b0;
  endtask

  task automatic clr();
    stp_net_model_inst.got.delete();
    n0 = stp_net_model_inst.n_pkt;
  endtask

  task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %0t value %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp_pkt(input stp_bq_t e);
    int k;
    logic bad;
    k = 0;
    while (stp_net_model_inst.n_pkt == n0 && k++ < 400) @(posedge sys_clk);
    checks++;
    bad = (stp_net_model_inst.n_pkt != n0 + 1) || (stp_net_model_inst.got.size() != e.size());
    foreach (e[i]) if (!bad && stp_net_model_inst.got[i] !== e[i]) bad = 1'b1;
    if (bad)
    begin
      n_fail++;
      $display("MISMATCH %0t packet differs, %0d bytes expected", $time, e.size());
    end
  endtask

  task close_out();
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  // event counters and the hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    n_close += (conn_close === 1'b1);
    n_probe += (ka_probe === 1'b1);
    if (cyc == 40000)
    begin
      n_fail++;
      close_out();
    end
  end

  initial
  begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd(stp_pkg::OFS_CTRL);
    cmp_val(d, 32'h180);
    rd(stp_pkg::OFS_ALIVE);
    cmp_val(d, 32'h7);
    rd(stp_pkg::OFS_MAXCONN);
    cmp_val(d, 32'h1);
    rd(8'h2c);
    cmp_val(32'(r), 32'(stp_pkg::RESP_SLVERR));
    wr(stp_pkg::OFS_STATUS, 32'h0);
    cmp_val(32'(r), 32'(stp_pkg::RESP_SLVERR));
    wr(stp_pkg::OFS_INT_EN, 32'h1);
    // length release, and no idle release while the gap timer is off
    wr(stp_pkg::OFS_PKTLEN, 32'h4);
    clr();
    s = {rnd8(), rnd8(), rnd8()};
    send(s);
    repeat (100) @(posedge sys_clk);
    cmp_val(stp_net_model_inst.n_pkt - n0, 0);
    s.push_back(rnd8());
    send({s[3]});
    cmp_pkt(s);
    cmp_val(irq, 1'b1);
    wr(stp_pkg::OFS_INT_CLR, 32'h1);
    repeat (2) @(posedge sys_clk);
    cmp_val(irq, 1'b0);
    // idle gap: bytes 20 cycles apart must not split the packet
    wr(stp_pkg::OFS_PKTLEN, 32'h0);
    wr(stp_pkg::OFS_FORCE, 32'h3); // three ms, 30 cycles, above the roughly 21 cycle byte gap
    clr();
    s = {rnd8(), rnd8(), rnd8()};
    foreach (s[i])
    begin
      send({s[i]});
      repeat (20) @(posedge sys_clk);
    end
    cmp_val(stp_net_model_inst.n_pkt - n0, 0);
    cmp_pkt(s);
    wr(stp_pkg::OFS_FORCE, 32'h0);
    // every delimiter process, single and paired delimiters
    wr(stp_pkg::OFS_DELIM, 32'h0a0d);
    for (int p = 0; p < 4; p++)
    begin
      nd = 1 + p % 2;
      slow <= p[0];
      wr(stp_pkg::OFS_CTRL, 32'h181 | 32'((nd - 1) * 2 + p * 4));
      clr();
      s = {rnd8(), rnd8()};
      if (nd == 2) s = {s, 8'h0d, rnd8(), 8'h0d, 8'h0a};
      else s = {s, 8'h0d};
      repeat (p % 3) s.push_back(rnd8());
      send(s);
      cmp_pkt(expect_pkt(s, p == 3 ? nd : 0));
    end
    // first delimiter off: strip ignored, buffer full releases
    slow <= 1'b0;
    wr(stp_pkg::OFS_CTRL, 32'h18c);
    clr();
    s = {};
    repeat (16) s.push_back(rnd8());
    s[5] = 8'h0d;
    send(s);
    cmp_pkt(s);
    // one unresponsive host holds all traffic unless skipping is on
    wr(stp_pkg::OFS_CTRL, 32'h181);
    conn_active <= 8'h03;
    host_unresp <= 8'h01;
    clr();
    s = {rnd8(), 8'h0d};
    send(s);
    repeat (60) @(posedge sys_clk);
    cmp_val(stp_net_model_inst.n_pkt - n0, 0);
    cmp_val(tx_en, 8'h02);
    host_unresp <= 8'h00;
    cmp_pkt(s);
    wr(stp_pkg::OFS_CTRL, 32'h191);
    host_unresp <= 8'h02;
    clr();
    s = {rnd8(), 8'h0d};
    send(s);
    cmp_pkt(s);
    host_unresp <= 8'h00;
    wr(stp_pkg::OFS_MAXCONN, 32'h2);
    repeat (3) @(posedge sys_clk);
    cmp_val(ok, 1'b0);
    conn_active <= 8'h01;
    repeat (3) @(posedge sys_clk);
    cmp_val(ok, 1'b1);
    // handshake lines on a dropped link
    link_up <= 1'b0;
    wr(stp_pkg::OFS_CTRL, 32'h1e0);
    repeat (3) @(posedge sys_clk);
    cmp_val({rts, dtr}, 2'b00);
    wr(stp_pkg::OFS_CTRL, 32'h180);
    repeat (3) @(posedge sys_clk);
    cmp_val({rts, dtr}, 2'b11);
    link_up <= 1'b1;
    // inactivity close, then keep-alive probing without answers
    a = n_close;
    wr(stp_pkg::OFS_INACT, 32'h3);
    repeat (60) @(posedge sys_clk);
    cmp_val(n_close != a, 1'b1);
    rd(stp_pkg::OFS_INT_STAT);
    cmp_val(d[1], 1'b1);
    wr(stp_pkg::OFS_INACT, 32'h0);
    a = n_probe;
    b = n_close;
    wr(stp_pkg::OFS_ALIVE, 32'h1);
    repeat (120) @(posedge sys_clk);
    cmp_val(n_probe != a, 1'b1);
    cmp_val(n_close != b, 1'b1);
    // a held keep-alive answer stops probing and keeps the connection open
    ka_resp <= 1'b1;
    repeat (3) @(posedge sys_clk);
    b = n_close;
    repeat (120) @(posedge sys_clk);
    cmp_val(n_close != b, 1'b0);
    close_out();
  end
endmodule // tb_stp_packer
